// [rtl/ife_consts.svh]
// constants for the interrupt flag and enable controller: offsets, field positions, reset values
// assumes it is included by bare name wherever these macros are needed
`ifndef IFE_CONSTS_SVH
`define IFE_CONSTS_SVH

// byte offsets on the apb register bus (one aligned word each)
`define IFE_OFS_EDGE       12'h000
`define IFE_OFS_CTRL_A     12'h004
`define IFE_OFS_CTRL_B     12'h008
`define IFE_OFS_MF_A       12'h00C
`define IFE_OFS_MF_B       12'h010

// register index, taken from paddr[4:2]
`define IFE_REG_EDGE       3'h0
`define IFE_REG_CTRL_A     3'h1
`define IFE_REG_CTRL_B     3'h2
`define IFE_REG_MF_A       3'h3
`define IFE_REG_MF_B       3'h4
`define IFE_REG_LAST       3'h4

// edge configuration fields (low bit of each two-bit select)
`define IFE_B_PIN0_SEL     0
`define IFE_B_PIN1_SEL     2
// primary control a
`define IFE_B_GIE          0
`define IFE_B_PIN0_EN      3'h1
`define IFE_B_TB0_EN       3'h2
`define IFE_B_TB1_EN       3'h3
`define IFE_B_PIN0_FLAG    3'h4
`define IFE_B_TB0_FLAG     3'h5
`define IFE_B_TB1_FLAG     3'h6
// primary control b
`define IFE_B_MF0_EN       3'h0
`define IFE_B_EE_EN        3'h1
`define IFE_B_ADC_EN       3'h2
`define IFE_B_PIN1_EN      3'h3
`define IFE_B_MF0_FLAG     3'h4
`define IFE_B_EE_FLAG      3'h5
`define IFE_B_ADC_FLAG     3'h6
`define IFE_B_PIN1_FLAG    3'h7
// multi-function control a and b
`define IFE_B_CMP_P_EN     3'h0
`define IFE_B_CMP_A_EN     3'h1
`define IFE_B_CMP_P_FLAG   3'h4
`define IFE_B_CMP_A_FLAG   3'h5

// flag indices inside the block
`define IFE_NFLAG          11
`define IFE_F_PIN0         0
`define IFE_F_PIN1         1
`define IFE_F_TB0          2
`define IFE_F_TB1          3
`define IFE_F_ADC          4
`define IFE_F_EE           5
`define IFE_F_MF0          6
`define IFE_F_T0A          7
`define IFE_F_T0P          8
`define IFE_F_T1A          9
`define IFE_F_T1P          10

// vectored sources, lowest index has highest priority
`define IFE_NSRC           7

// reset values
`define IFE_RST_BYTE       8'h00
`define IFE_RST_WORD       32'h0000_0000

`endif

// [rtl/ife_ctrl.sv]
// interrupt flag and enable controller: register file on apb, flags, enables, request to the core
// assumes one clock, synchronous active-low reset, an apb master, and one-cycle event pulses
//
// How it works
// - edge select: off, rise, fall, both
// - pin0 select in edge bits 1..0
// - pin1 select in edge bits 3..2
// - unimplemented bits read zero, ignore writes
// - ctrl a bit 0 is global enable
// - flags show pending, software read and write
// - ctrl a time base flags and enables
// - ctrl a pin0 flag 4, enable 1
// - ctrl b adc, eeprom, multi-function bits
// - primary, multi-function and edge register groups
// - events set flags, software sets enables
// - requests from pins, timers, time bases, converters
// - accepted request interrupts the core program
// - flag interrupts only when enabled
// - service entry clears global enable
// - multi-function compare flags 5,4, enables 1,0
// - any set flag wakes the device
//
// Design decisions made here: the register addresses and the APB register port.
`include "ife_consts.svh"

module ife_ctrl (
  input  wire logic        sys_clk,          // system clock, 100 MHz
  input  wire logic        rst_n,            // synchronous reset, active low
  // apb slave
  input  wire logic        psel,             // slave select
  input  wire logic        penable,          // access phase
  input  wire logic        pwrite,           // write when high
  input  wire logic [11:0] paddr,            // byte address
  input  wire logic [31:0] pwdata,           // write data, low byte used
  input  wire logic [3:0]  pstrb,            // byte strobes, lane 0 used
  output logic      [31:0] prdata,           // read data
  output logic             pready,           // always ready, no wait states
  output logic             pslverr,          // unmapped access
  // event sources
  input  wire logic [1:0]  pin_in,           // external interrupt pins
  input  wire logic        tb0_evt,          // time base 0 tick
  input  wire logic        tb1_evt,          // time base 1 tick
  input  wire logic        adc_done_evt,     // conversion complete
  input  wire logic        eeprom_done_evt,  // eeprom write complete
  input  wire logic        tmr0_cmp_a_evt,   // timer 0 compare a match
  input  wire logic        tmr0_cmp_p_evt,   // timer 0 compare p match
  input  wire logic        tmr1_cmp_a_evt,   // timer 1 compare a match
  input  wire logic        tmr1_cmp_p_evt,   // timer 1 compare p match
  // core side
  input  wire logic        irq_ack,          // core enters service, one-cycle pulse
  output logic             irq_req,          // request to the core
  output logic      [2:0]  irq_vec,          // winning source index
  output logic             wake_req          // wake from sleep or idle
);

  // where each flag lives: register, flag bit, enable bit
  localparam logic [2:0] FLAG_REG [`IFE_NFLAG] = '{
    `IFE_REG_CTRL_A, `IFE_REG_CTRL_B, `IFE_REG_CTRL_A, `IFE_REG_CTRL_A,
    `IFE_REG_CTRL_B, `IFE_REG_CTRL_B, `IFE_REG_CTRL_B,
    `IFE_REG_MF_A,   `IFE_REG_MF_A,   `IFE_REG_MF_B,   `IFE_REG_MF_B
  };
  localparam logic [2:0] FLAG_FBIT [`IFE_NFLAG] = '{
    `IFE_B_PIN0_FLAG, `IFE_B_PIN1_FLAG, `IFE_B_TB0_FLAG, `IFE_B_TB1_FLAG,
    `IFE_B_ADC_FLAG,  `IFE_B_EE_FLAG,   `IFE_B_MF0_FLAG,
    `IFE_B_CMP_A_FLAG, `IFE_B_CMP_P_FLAG, `IFE_B_CMP_A_FLAG, `IFE_B_CMP_P_FLAG
  };
  localparam logic [2:0] FLAG_EBIT [`IFE_NFLAG] = '{
    `IFE_B_PIN0_EN, `IFE_B_PIN1_EN, `IFE_B_TB0_EN, `IFE_B_TB1_EN,
    `IFE_B_ADC_EN,  `IFE_B_EE_EN,   `IFE_B_MF0_EN,
    `IFE_B_CMP_A_EN, `IFE_B_CMP_P_EN, `IFE_B_CMP_A_EN, `IFE_B_CMP_P_EN
  };
  // the tables above carry the layout of every flag and enable

  // bus decode
  logic [2:0]            reg_idx;        // register index from the address
  logic                  addr_ok;        // address maps to a register
  logic                  setup_ph;       // apb setup cycle
  logic                  access_ph;      // apb access cycle
  logic                  wr_fire;        // write takes effect this edge
  logic                  edge_we;        // write to edge configuration
  logic                  ctrl_a_we;      // write to primary control a

  // register state
  logic [1:0]            sel0_q;         // pin0 edge select
  logic [1:0]            sel0_d;
  logic [1:0]            sel1_q;         // pin1 edge select
  logic [1:0]            sel1_d;
  logic                  gie_q;          // global interrupt enable
  logic                  gie_d;
  logic [`IFE_NFLAG-1:0] flag_q;         // request flags
  logic [`IFE_NFLAG-1:0] flag_d;
  logic [`IFE_NFLAG-1:0] en_q;           // per-source enables
  logic [`IFE_NFLAG-1:0] en_d;
  logic [`IFE_NFLAG-1:0] flag_we;        // write hits the register of this flag
  logic [`IFE_NFLAG-1:0] flag_set;       // hardware set this cycle
  logic [31:0]           prdata_q;       // captured read data
  logic [7:0]            rd_bits;        // read view of the addressed register

  // event and request path
  logic [1:0]            pin_evt;        // qualified pin edges
  logic                  mf0_set;        // a timer sub-flag fired while enabled
  logic [`IFE_NFLAG-1:0] pend_d;         // next pending and enabled flags
  logic [`IFE_NSRC-1:0]  src_req;        // vectored sources
  logic                  src_any;        // any vectored source pending
  logic [2:0]            src_idx;        // priority winner
  logic                  irq_req_q;      // registered request
  logic [2:0]            irq_vec_q;      // registered vector index
  logic                  wake_q;         // registered wake

  // apb decode: registers sit in the first five words of the window
  assign reg_idx   = paddr[4:2];
  assign addr_ok   = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) && (reg_idx <= `IFE_REG_LAST);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  // only lane 0 holds register bits; a write without it changes nothing
  assign wr_fire   = access_ph & pwrite & pstrb[0] & addr_ok;
  assign edge_we   = wr_fire & (reg_idx == `IFE_REG_EDGE);
  assign ctrl_a_we = wr_fire & (reg_idx == `IFE_REG_CTRL_A);

  // zero wait states; unmapped addresses answer with an error and read zero
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_ok;
  assign prdata  = prdata_q;

  // edge select fields, only four bits of the register exist
  assign sel0_d = edge_we ? pwdata[`IFE_B_PIN0_SEL +: 2] : sel0_q;
  assign sel1_d = edge_we ? pwdata[`IFE_B_PIN1_SEL +: 2] : sel1_q;

  // service entry beats a software write in the same cycle, so nesting needs a later write
  assign gie_d = irq_ack ? 1'b0 : (ctrl_a_we ? pwdata[`IFE_B_GIE] : gie_q);

  // edge configuration and global enable flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel0_q <= 2'h0;
      sel1_q <= 2'h0;
      gie_q  <= 1'b0;
    end else begin
      sel0_q <= sel0_d;
      sel1_q <= sel1_d;
      gie_q  <= gie_d;
    end
  end

  // one synchronising edge detector per pin
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      ife_edge_det u_edge (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin_in    (pin_in[p]),
        .edge_mode (ife_pkg::ife_edge_mode_t'((p == 0) ? sel0_q : sel1_q)),
        .edge_evt  (pin_evt[p])
      );
    end
  endgenerate

  // the shared vector collects enabled timer matches; a disabled sub-source stays silent
  assign mf0_set = (tmr0_cmp_a_evt & en_q[`IFE_F_T0A]) | (tmr0_cmp_p_evt & en_q[`IFE_F_T0P]) |
                   (tmr1_cmp_a_evt & en_q[`IFE_F_T1A]) | (tmr1_cmp_p_evt & en_q[`IFE_F_T1P]);

  // hardware set sources
  assign flag_set[`IFE_F_PIN0] = pin_evt[0];
  assign flag_set[`IFE_F_PIN1] = pin_evt[1];
  assign flag_set[`IFE_F_TB0]  = tb0_evt;
  assign flag_set[`IFE_F_TB1]  = tb1_evt;
  assign flag_set[`IFE_F_ADC]  = adc_done_evt;
  assign flag_set[`IFE_F_EE]   = eeprom_done_evt;
  assign flag_set[`IFE_F_MF0]  = mf0_set;
  assign flag_set[`IFE_F_T0A]  = tmr0_cmp_a_evt;
  assign flag_set[`IFE_F_T0P]  = tmr0_cmp_p_evt;
  assign flag_set[`IFE_F_T1A]  = tmr1_cmp_a_evt;
  assign flag_set[`IFE_F_T1P]  = tmr1_cmp_p_evt;

  // per flag: write path, set-wins merge, enable path and the flops
  generate
    for (genvar i = 0; i < `IFE_NFLAG; i++) begin : g_flag
      assign flag_we[i] = wr_fire & (reg_idx == FLAG_REG[i]);
      // a set in the cycle of a clearing write is kept
      assign flag_d[i]  = flag_set[i] | (flag_we[i] ? pwdata[FLAG_FBIT[i]] : flag_q[i]);
      assign en_d[i]    = flag_we[i] ? pwdata[FLAG_EBIT[i]] : en_q[i];
      // flag stays set: only a write or reset ever lowers it
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          flag_q[i] <= 1'b0;
          en_q[i]   <= 1'b0;
        end else begin
          flag_q[i] <= flag_d[i];
          en_q[i]   <= en_d[i];
        end
      end
    end
  endgenerate

  // read view: only implemented bits are filled, the rest stay zero
  always_comb begin
    rd_bits = `IFE_RST_BYTE;
    if (addr_ok) begin
      if (reg_idx == `IFE_REG_EDGE) begin
        rd_bits[`IFE_B_PIN0_SEL +: 2] = sel0_q;
        rd_bits[`IFE_B_PIN1_SEL +: 2] = sel1_q;
      end
      if (reg_idx == `IFE_REG_CTRL_A) begin
        rd_bits[`IFE_B_GIE] = gie_q;
      end
      for (int i = 0; i < `IFE_NFLAG; i++) begin
        if (reg_idx == FLAG_REG[i]) begin
          rd_bits[FLAG_FBIT[i]] = flag_q[i];
          rd_bits[FLAG_EBIT[i]] = en_q[i];
        end
      end
    end
  end

  // read data is captured in the setup cycle and shown through the access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_q <= `IFE_RST_WORD;
    end else if (setup_ph) begin
      prdata_q <= {24'h00_0000, rd_bits};
    end
  end

  // a flag reaches the core only through its own enable; timer sub-flags use the shared vector
  assign pend_d = flag_d & en_d;
  assign src_req = {pend_d[`IFE_F_TB1], pend_d[`IFE_F_TB0], pend_d[`IFE_F_ADC], pend_d[`IFE_F_EE],
                    pend_d[`IFE_F_MF0], pend_d[`IFE_F_PIN1], pend_d[`IFE_F_PIN0]};

  // fixed priority among simultaneous requests
  ife_prio_enc u_prio (
    .req (src_req),
    .any (src_any),
    .idx (src_idx)
  );

  // outputs are registered from next-state values so they match the flops with no lag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 3'h0;
      wake_q    <= 1'b0;
    end else begin
      irq_req_q <= gie_d & src_any;
      irq_vec_q <= src_idx;
      wake_q    <= |flag_d;
    end
  end

  // wake ignores every enable, so clear every flag before sleep to avoid waking
  assign irq_req  = irq_req_q;
  assign irq_vec  = irq_vec_q;
  assign wake_req = wake_q;

  // ---- checks ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [`IFE_NFLAG-1:0] en_view;   // current enabled pending flags
  logic [`IFE_NSRC-1:0]  src_view;  // current vectored sources
  assign en_view  = flag_q & en_q;
  assign src_view = {en_view[`IFE_F_TB1], en_view[`IFE_F_TB0], en_view[`IFE_F_ADC], en_view[`IFE_F_EE],
                     en_view[`IFE_F_MF0], en_view[`IFE_F_PIN1], en_view[`IFE_F_PIN0]};

  a_flag_set_wins: assert property (1'b1 |=> ((flag_q & $past(flag_set)) == $past(flag_set))) else $error("set lost");
  a_flag_holds: assert property ((!$past(wr_fire)) |-> ((flag_q & $past(flag_q)) == $past(flag_q))) else $error("flag fell");
  a_global_gate: assert property (!gie_q |-> !irq_req) else $error("request with global enable off");
  a_enable_gate: assert property (irq_req |-> (|src_view)) else $error("request without enabled flag");
  a_ack_blocks: assert property (irq_ack |=> (!gie_q && !irq_req) ##1 (!gie_q || $past(ctrl_a_we))) else $error("ack kept enable");
  a_wake_any: assert property ((|flag_q) == wake_req) else $error("wake mismatch");
  a_rd_unimpl: assert property ((setup_ph && reg_idx == `IFE_REG_EDGE) |=> (prdata[7:4] == 4'h0 && prdata[31:8] == 24'h0)) else $error("unimplemented bits read nonzero");
  a_rd_flags: assert property ((setup_ph && addr_ok && reg_idx == `IFE_REG_CTRL_A) |=> (prdata[6:4] == $past({flag_q[`IFE_F_TB1], flag_q[`IFE_F_TB0], flag_q[`IFE_F_PIN0]}))) else $error("flag read wrong");
  a_edge_write: assert property (edge_we |=> (sel1_q == $past(pwdata[3:2]) && sel0_q == $past(pwdata[1:0]))) else $error("edge select write lost");
  a_vec_lowest: assert property (irq_req && src_view[0] |-> irq_vec == 3'h0) else $error("priority wrong");
  a_pin_to_flag: assert property (pin_evt[0] |=> flag_q[`IFE_F_PIN0]) else $error("pin0 flag not set");

  c_irq_taken: cover property (irq_req ##1 irq_ack ##1 !gie_q);
  c_set_clear_clash: cover property (flag_set[`IFE_F_ADC] && flag_we[`IFE_F_ADC] && !pwdata[`IFE_B_ADC_FLAG]);
  c_pin1_both: cover property (sel1_q == 2'h3 ##0 pin_evt[1] ##[1:20] pin_evt[1]);
  c_wake_disabled: cover property (wake_req && !irq_req && en_q == '0);

endmodule // ife_ctrl

// [rtl/ife_edge_det.sv]
// edge detector for one external interrupt pin, with its own synchroniser
// assumes sys_clk and a synchronous active-low reset; the pin may be asynchronous
module ife_edge_det (
  input  wire logic                  sys_clk,    // system clock
  input  wire logic                  rst_n,      // synchronous reset, active low
  input  wire logic                  pin_in,     // raw pin level
  input  ife_pkg::ife_edge_mode_t    edge_mode,  // trigger selection
  output logic                       edge_evt    // one-cycle pulse per qualifying edge
);

  logic       meta_q;   // first synchroniser stage, read only by sync_q
  logic       sync_q;   // second stage, safe to use
  logic       prev_q;   // sync_q one cycle ago
  logic       rise;     // synchronised rising edge
  logic       fall;     // synchronised falling edge
  logic       hit;      // edge matches the selected mode
  logic       evt_q;    // registered pulse

  // two-flop synchroniser then history flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // history runs even when off, so switching mode never sees a stale edge
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // mode decode
  always_comb begin
    case (edge_mode)
      ife_pkg::EDGE_OFF:  hit = 1'b0;
      ife_pkg::EDGE_RISE: hit = rise;
      ife_pkg::EDGE_FALL: hit = fall;
      ife_pkg::EDGE_BOTH: hit = rise | fall;
      default:            hit = 1'b0;
    endcase
  end

  // one pulse per edge, since prev_q catches up after one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= hit;
    end
  end

  assign edge_evt = evt_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_edge_rise_hit: assert property ((edge_mode == ife_pkg::EDGE_RISE && rise) |=> edge_evt) else $error("rise missed");
  a_edge_off_mute: assert property ((edge_mode == ife_pkg::EDGE_OFF) |=> !edge_evt) else $error("pulse while off");
  a_edge_once: assert property (edge_evt |=> !edge_evt) else $error("edge counted twice");

endmodule // ife_edge_det

// [rtl/ife_pkg.sv]
// types shared by the interrupt flag and enable controller
// assumes nothing of its surroundings
package ife_pkg;

  // external pin trigger selection, encoded 00 off, 01 rise, 10 fall, 11 both
  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } ife_edge_mode_t;

endpackage : ife_pkg

// [rtl/ife_prio_enc.sv]
// fixed priority encoder over the vectored interrupt sources
// assumes the lowest request index is the most urgent
`include "ife_consts.svh"

module ife_prio_enc (
  input  wire logic [`IFE_NSRC-1:0] req,   // pending and enabled sources
  output logic                      any,   // at least one request
  output logic [2:0]                idx    // winning source index
);

  // scan from the top down so the lowest set index is left last
  always_comb begin
    any = 1'b0;
    idx = 3'h0;
    for (int i = `IFE_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end

endmodule // ife_prio_enc

// [tb/ife_core_mdl.sv]
// behavioural model of the cpu core side: takes a pending request into service
// assumes one clock domain and a request level from the controller
module ife_core_mdl (
  input  wire logic       sys_clk,  // system clock
  input  wire logic       rst_n,    // synchronous reset, active low
  input  wire logic       irq_req,  // request level from the controller
  input  wire logic       ack_en,   // bench lets the core accept
  input  wire logic [3:0] ack_dly,  // stall cycles before the core accepts
  output logic            irq_ack   // one-cycle service entry pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;  // cycles the request has waited so far

  // stall, then accept once; never pulse twice in a row, a real core is busy stacking
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !ack_en || !irq_req || irq_ack) begin
      wait_q  <= 4'h0;
      irq_ack <= 1'b0;
    end else if (wait_q == ack_dly) begin
      irq_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // ife_core_mdl

// [tb/tb.sv]
// self-checking bench for the interrupt flag and enable controller
// assumes the core model beside it and an apb slave that answers by pready
`include "ife_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;   // 100 MHz
  logic        rst_n = 1'b0;     // synchronous, active low
  logic        psel = 1'b0;      // apb select
  logic        penable = 1'b0;   // apb access phase
  logic        pwrite = 1'b0;    // apb direction
  logic [11:0] paddr = 12'h000;  // apb byte address
  logic [31:0] pwdata = 32'h0;   // apb write data
  logic [3:0]  pstrb = 4'hF;     // all lanes on
  logic [31:0] prdata;           // apb read data
  logic        pready;           // apb ready
  logic        pslverr;          // apb error
  logic [1:0]  pin_in = 2'h0;    // external pins
  logic [7:0]  ev = 8'h00;       // tb0 tb1 adc ee t0a t0p t1a t1p
  logic        irq_ack;          // from the core model
  logic        irq_req;          // to the core
  logic [2:0]  irq_vec;          // winning source
  logic        wake_req;         // wake level
  logic        ack_en = 1'b0;    // core may accept
  logic [3:0]  ack_dly = 4'h3;   // core stall
  logic [31:0] rd;               // last read data
  logic        err;              // last pslverr
  int          error_cnt = 0;
  int          comparisons = 0;

  // register offsets and the bits each one implements
  logic [11:0] ofs [5] = '{`IFE_OFS_EDGE, `IFE_OFS_CTRL_A, `IFE_OFS_CTRL_B, `IFE_OFS_MF_A, `IFE_OFS_MF_B};
  logic [7:0]  msk [5] = '{8'h0F, 8'h7F, 8'hFF, 8'h33, 8'h33};
  // where each event lands: register and flag bit
  logic [11:0] ea [8] = '{`IFE_OFS_CTRL_A, `IFE_OFS_CTRL_A, `IFE_OFS_CTRL_B, `IFE_OFS_CTRL_B,
                          `IFE_OFS_MF_A, `IFE_OFS_MF_A, `IFE_OFS_MF_B, `IFE_OFS_MF_B};
  logic [7:0]  eb [8] = '{8'h20, 8'h40, 8'h40, 8'h20, 8'h20, 8'h10, 8'h20, 8'h10};

  // free running clock
  always #5 sys_clk = ~sys_clk;

  ife_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .tb0_evt(ev[0]), .tb1_evt(ev[1]), .adc_done_evt(ev[2]), .eeprom_done_evt(ev[3]),
    .tmr0_cmp_a_evt(ev[4]), .tmr0_cmp_p_evt(ev[5]), .tmr1_cmp_a_evt(ev[6]), .tmr1_cmp_p_evt(ev[7]),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec), .wake_req(wake_req));

  ife_core_mdl core (.sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req), .ack_en(ack_en),
    .ack_dly(ack_dly), .irq_ack(irq_ack));

  // verdict, reached from the main sequence or the watchdog
  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; hit raises the time base 0 event in the access cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic hit);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    ev[0] <= hit;
    @(posedge sys_clk);
    // hold everything until pready is seen at an edge; only the watchdog ends this wait
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ev[0] <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 1'b0);
    chk(rd, {24'h000000, exp});
    chk(err, 1'b0);
  endtask

  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge sys_clk);
    ev <= 8'h00;
    @(posedge sys_clk);
  endtask

  // reset values and an unmapped offset
  task automatic sc_reset();
    for (int i = 0; i < 5; i++) rchk(ofs[i], 8'h00);
    apb(1'b0, 12'h014, 8'h00, 1'b0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  // all ones then all zeros: only implemented bits stick, flags writable
  task automatic sc_masks();
    // a write without lane 0 must leave the register alone
    pstrb <= 4'h0;
    apb(1'b1, `IFE_OFS_EDGE, 8'hFF, 1'b0);
    pstrb <= 4'hF;
    rchk(`IFE_OFS_EDGE, 8'h00);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ofs[i], 8'hFF, 1'b0);
      rchk(ofs[i], msk[i]);
      apb(1'b1, ofs[i], 8'h00, 1'b0);
      rchk(ofs[i], 8'h00);
    end
  endtask

  // every time base, adc, eeprom and timer event sets its own flag and wakes even with all enables off
  task automatic sc_events();
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      chk(wake_req, 1'b1);
      chk(irq_req, 1'b0);
      rchk(ea[i], eb[i]);
      apb(1'b1, ea[i], 8'h00, 1'b0);
    end
    chk(wake_req, 1'b0);
  endtask

  // a timer match with its sub-enable on also raises the shared multi-function flag
  task automatic sc_mf();
    apb(1'b1, `IFE_OFS_MF_A, 8'h02, 1'b0);
    pulse(8'h10);
    rchk(`IFE_OFS_CTRL_B, 8'h10);
    rchk(`IFE_OFS_MF_A, 8'h22);
    apb(1'b1, `IFE_OFS_MF_A, 8'h00, 1'b0);
    apb(1'b1, `IFE_OFS_CTRL_B, 8'h00, 1'b0);
    chk(wake_req, 1'b0);
  endtask

  // global enable gates, the core takes the request and service clears the enable
  task automatic sc_irq();
    int n;
    n = 0;
    apb(1'b1, `IFE_OFS_CTRL_B, 8'h04, 1'b0);
    pulse(8'h04);
    chk(irq_req, 1'b0);
    apb(1'b1, `IFE_OFS_CTRL_A, 8'h01, 1'b0);
    chk(irq_req, 1'b1);
    chk(irq_vec, 3'h4);
    ack_en <= 1'b1;
    while (irq_ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 20, 1'b1);
    ack_en <= 1'b0;
    @(posedge sys_clk);
    chk(irq_req, 1'b0);
    rchk(`IFE_OFS_CTRL_A, 8'h00);
    pulse(8'h08);
    rchk(`IFE_OFS_CTRL_B, 8'h64);
    apb(1'b1, `IFE_OFS_CTRL_B, 8'h00, 1'b0);
  endtask

  // a hardware set in the same edge as a software clear keeps the flag
  task automatic sc_set_wins();
    apb(1'b1, `IFE_OFS_CTRL_A, 8'h00, 1'b1);
    rchk(`IFE_OFS_CTRL_A, 8'h20);
    apb(1'b1, `IFE_OFS_CTRL_A, 8'h00, 1'b0);
    rchk(`IFE_OFS_CTRL_A, 8'h00);
  endtask

  // every select code on both pins, one rise and one fall each
  task automatic sc_pins();
    logic [7:0]  cfg;
    logic [7:0]  fb;
    logic [11:0] fr;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        cfg = 8'(m << (2 * p));
        fb = p ? 8'h80 : 8'h10;
        fr = p ? `IFE_OFS_CTRL_B : `IFE_OFS_CTRL_A;
        apb(1'b1, `IFE_OFS_EDGE, cfg, 1'b0);
        rchk(`IFE_OFS_EDGE, cfg);
        pin_in[p] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rchk(fr, m[0] ? fb : 8'h00);
        apb(1'b1, fr, 8'h00, 1'b0);
        rchk(fr, 8'h00);
        pin_in[p] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rchk(fr, m[1] ? fb : 8'h00);
        apb(1'b1, fr, 8'h00, 1'b0);
      end
    end
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    sc_reset();
    sc_masks();
    sc_events();
    sc_mf();
    sc_irq();
    sc_set_wins();
    sc_pins();
    close_out();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    #50000;
    error_cnt++;
    close_out();
  end
endmodule // tb
